// File: pmc_pkg.sv
// package of offsets, fields and encodings for the shut-down / wake-up power control block
package pmc_pkg;
   // -----------------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_POWER_COMMAND     = 8'h28;
   localparam logic [7:0] OFS_POWER_MODE_CONFIG = 8'h2C;
   localparam logic [7:0] OFS_OSC_PLL_STATUS    = 8'h30;
   localparam logic [7:0] OFS_INT_ENABLE_SET    = 8'h34;
   localparam logic [7:0] OFS_OSC_PLL_CONFIG    = 8'h40;
   localparam logic [7:0] OFS_EVENT_STATUS      = 8'h44;
   localparam logic [7:0] OFS_EVENT_MASK        = 8'h48;
   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int CMD_SHUTDOWN_BIT    = 0;
   localparam int CMD_WAKE_ACK_BIT    = 1;
   localparam int MODE_SHD_SEL_LSB    = 0;
   localparam int MODE_ACK_SEL_LSB    = 2;
   localparam int MODE_ALARM_WAKE_BIT = 4;
   localparam int MODE_ALARM_SHD_BIT  = 5;
   localparam int MODE_EDGE_LSB       = 6;
   localparam int MODE_W              = 8;
   localparam logic [7:0] MODE_RESET  = 8'h01;
   localparam int CFG_OSC_EN_BIT      = 1;
   localparam int CFG_MUL_LSB         = 8;
   localparam int CFG_OSC_CNT_LSB     = 16;
   localparam int CFG_PLL_CNT_LSB     = 24;
   localparam int STAT_OSC_BIT        = 0;
   localparam int STAT_LOCK_BIT       = 1;
   // events: oscillator stable, pll lock, wake-up, alarm shut-down
   localparam int EVT_OSC             = 0;
   localparam int EVT_PLL             = 1;
   localparam int EVT_WAKE            = 2;
   localparam int EVT_ALARM_SHD       = 3;
   localparam int EVT_W               = 4;
   // -----------------------------------------------------------------
   // timing and bus codes
   // -----------------------------------------------------------------
   localparam int OSC_TICK_DIV        = 8;
   localparam int DIV_W               = $clog2(OSC_TICK_DIV);
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   // pin drive codes, 11 reserved
   typedef enum logic [1:0] {
      PIN_TRI  = 2'b00,
      PIN_LOW  = 2'b01,
      PIN_HIGH = 2'b10,
      PIN_RSVD = 2'b11
   } pmc_pin_sel_type;
   typedef enum logic [1:0] {
      EDGE_NONE = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_BOTH = 2'b11
   } pmc_edge_type;
endpackage

// File: pmc_shutdown_wakeup.sv
// shut-down / wake-up pin control with oscillator and pll status, AHB-Lite slave
module pmc_shutdown_wakeup
   import pmc_pkg::*;
(
   input  wire logic        CLK_SYS_IN,
   input  wire logic        SRST_IN,
   input  wire logic        HSEL_IN,
   input  wire logic [31:0] HADDR_IN,
   input  wire logic [1:0]  HTRANS_IN,
   input  wire logic        HWRITE_IN,
   input  wire logic [2:0]  HSIZE_IN,
   input  wire logic [31:0] HWDATA_IN,
   input  wire logic        HREADY_IN,
   output logic             HREADYOUT_OUT,
   output logic             HRESP_OUT,
   output logic [31:0]      HRDATA_OUT,
   input  wire logic        SLOW_TICK_IN,
   input  wire logic        WAKEUP_IN,
   input  wire logic        RTC_ALARM_IN,
   output logic             SHUTDOWN_ALARM_PIN_OUT,
   output logic             SHUTDOWN_ALARM_PIN_OE_OUT,
   output logic             WAKE_ACK_PIN_OUT,
   output logic             WAKE_ACK_PIN_OE_OUT,
   output logic             WAKE_REQ_OUT,
   output logic             IRQ_OUT
);

   // -----------------------------------------------------------------
   // functions
   // -----------------------------------------------------------------
   // new {oe, level} of a pin; a reserved code leaves the pin alone
   function automatic logic [1:0] pin_drive(input logic [1:0] sel,
                                            input logic [1:0] cur);
      pin_drive = cur;
      unique case (pmc_pin_sel_type'(sel))
         PIN_TRI:  pin_drive = 2'b00;
         PIN_LOW:  pin_drive = 2'b10;
         PIN_HIGH: pin_drive = 2'b11;
         PIN_RSVD: pin_drive = cur;
      endcase
   endfunction

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic              wr_pend_reg,  wr_pend_next;
   logic [7:0]        wr_addr_reg,  wr_addr_next;
   logic [31:0]       rdata_reg,    rdata_next;
   logic              hready_reg;
   logic              hresp_reg;
   logic [MODE_W-1:0] mode_reg,     mode_next;
   logic              osc_en_reg,   osc_en_next;
   logic [5:0]        mul_reg,      mul_next;
   logic [7:0]        osc_cfg_reg,  osc_cfg_next;
   logic [5:0]        pll_cfg_reg,  pll_cfg_next;
   logic [DIV_W-1:0]  div_reg,      div_next;
   logic [7:0]        osc_cnt_reg,  osc_cnt_next;
   logic [5:0]        pll_cnt_reg,  pll_cnt_next;
   logic              osc_q_reg,    osc_q_next;
   logic              lock_q_reg,   lock_q_next;
   logic              wake_q_reg,   wake_q_next;
   logic              alarm_q_reg,  alarm_q_next;
   logic [1:0]        shd_pin_reg,  shd_pin_next;
   logic [1:0]        ack_pin_reg,  ack_pin_next;
   logic [EVT_W-1:0]  status_reg,   status_next;
   logic [EVT_W-1:0]  mask_reg,     mask_next;
   logic              wake_req_reg, wake_req_next;
   logic              irq_reg,      irq_next;
   logic              addr_phase;
   logic              wr_cmd, wr_mode, wr_ier, wr_cfg, wr_stat, wr_mask;
   logic              osc_stable, pll_lock, alarm_rise, edge_hit;
   logic              wake_evt, alarm_shd;

   // -----------------------------------------------------------------
   // AHB-Lite slave
   // -----------------------------------------------------------------
   // zero wait states: read data is picked in the address phase
   assign addr_phase = HSEL_IN && HTRANS_IN == HTRANS_NONSEQ && HREADY_IN;
   assign wr_cmd  = wr_pend_reg && wr_addr_reg == OFS_POWER_COMMAND;
   assign wr_mode = wr_pend_reg && wr_addr_reg == OFS_POWER_MODE_CONFIG;
   assign wr_ier  = wr_pend_reg && wr_addr_reg == OFS_INT_ENABLE_SET;
   assign wr_cfg  = wr_pend_reg && wr_addr_reg == OFS_OSC_PLL_CONFIG;
   assign wr_stat = wr_pend_reg && wr_addr_reg == OFS_EVENT_STATUS;
   assign wr_mask = wr_pend_reg && wr_addr_reg == OFS_EVENT_MASK;

   // read mux; write-only and unmapped offsets read as zero
   // stored fields are read from their next values, so a write whose data
   // phase overlaps this address phase is already seen by the read
   always_comb begin
      wr_pend_next = addr_phase && HWRITE_IN;
      wr_addr_next = addr_phase ? {HADDR_IN[7:2], 2'b00} : wr_addr_reg;
      rdata_next   = 32'h0000_0000;
      if (addr_phase && !HWRITE_IN) begin
         unique case ({HADDR_IN[7:2], 2'b00})
            OFS_POWER_MODE_CONFIG: rdata_next[MODE_W-1:0] = mode_next;
            OFS_OSC_PLL_STATUS: begin
               rdata_next[STAT_OSC_BIT]  = osc_stable;
               rdata_next[STAT_LOCK_BIT] = pll_lock;
            end
            OFS_OSC_PLL_CONFIG: begin
               rdata_next[CFG_OSC_EN_BIT]                 = osc_en_next;
               rdata_next[CFG_MUL_LSB +: 6]               = mul_next;
               rdata_next[CFG_OSC_CNT_LSB +: 8]           = osc_cfg_next;
               rdata_next[CFG_PLL_CNT_LSB +: 6]           = pll_cfg_next;
            end
            OFS_EVENT_STATUS: rdata_next[EVT_W-1:0] = status_next;
            OFS_EVENT_MASK:   rdata_next[EVT_W-1:0] = mask_next;
            default:          rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // bus registers
   always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rdata_reg   <= 32'h0000_0000;
         hready_reg  <= 1'b1;
         hresp_reg   <= 1'b0;
      end else begin
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         rdata_reg   <= rdata_next;
         hready_reg  <= 1'b1;
         hresp_reg   <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // configuration and start-up counters
   // -----------------------------------------------------------------
   assign osc_stable = osc_en_reg && osc_cnt_reg == 8'h00;
   assign pll_lock   = osc_stable && mul_reg != 6'h00 && pll_cnt_reg == 6'h00;

   // oscillator count loads on the enabling write and clears on disable, pll count loads when the multiplier changes; other rewrites keep the counts
   always_comb begin
      mode_next    = wr_mode ? HWDATA_IN[MODE_W-1:0] : mode_reg;
      osc_en_next  = wr_cfg ? HWDATA_IN[CFG_OSC_EN_BIT] : osc_en_reg;
      mul_next     = wr_cfg ? HWDATA_IN[CFG_MUL_LSB +: 6] : mul_reg;
      osc_cfg_next = wr_cfg ? HWDATA_IN[CFG_OSC_CNT_LSB +: 8] : osc_cfg_reg;
      pll_cfg_next = wr_cfg ? HWDATA_IN[CFG_PLL_CNT_LSB +: 6] : pll_cfg_reg;
      div_next     = SLOW_TICK_IN ? div_reg + 1'b1 : div_reg;
      osc_cnt_next = osc_cnt_reg;
      pll_cnt_next = pll_cnt_reg;
      // the divider runs free, so the first step after a load may come early
      // start-up count ticks once every eight slow clocks
      if (SLOW_TICK_IN && div_reg == DIV_W'(OSC_TICK_DIV - 1) && osc_cnt_reg != 8'h00)
         osc_cnt_next = osc_cnt_reg - 1'b1;
      if (!osc_en_next)
         osc_cnt_next = 8'h00;
      else if (wr_cfg && !osc_en_reg && osc_cfg_next != 8'h00)
         osc_cnt_next = osc_cfg_next;
      if (SLOW_TICK_IN && pll_cnt_reg != 6'h00)
         pll_cnt_next = pll_cnt_reg - 1'b1;
      if (wr_cfg && mul_next != mul_reg && mul_next != 6'h00 && pll_cfg_next != 6'h00)
         pll_cnt_next = pll_cfg_next;
   end

   // configuration registers
   always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN) begin
         mode_reg    <= MODE_RESET;
         osc_en_reg  <= 1'b0;
         mul_reg     <= 6'h00;
         osc_cfg_reg <= 8'h00;
         pll_cfg_reg <= 6'h00;
         div_reg     <= '0;
         osc_cnt_reg <= 8'h00;
         pll_cnt_reg <= 6'h00;
      end else begin
         mode_reg    <= mode_next;
         osc_en_reg  <= osc_en_next;
         mul_reg     <= mul_next;
         osc_cfg_reg <= osc_cfg_next;
         pll_cfg_reg <= pll_cfg_next;
         div_reg     <= div_next;
         osc_cnt_reg <= osc_cnt_next;
         pll_cnt_reg <= pll_cnt_next;
      end
   end

   // -----------------------------------------------------------------
   // wake-up, alarm and pin control
   // -----------------------------------------------------------------
   assign alarm_rise = RTC_ALARM_IN && !alarm_q_reg;
   assign wake_evt   = edge_hit || (alarm_rise && mode_reg[MODE_ALARM_WAKE_BIT]);
   assign alarm_shd  = alarm_rise && mode_reg[MODE_ALARM_SHD_BIT]
                       && !mode_reg[MODE_ALARM_WAKE_BIT];

   // edge select on the wake input
   // the sample flop resets to the idle low level, so reset makes no false edge
   always_comb begin
      unique case (pmc_edge_type'(mode_reg[MODE_EDGE_LSB +: 2]))
         EDGE_NONE: edge_hit = 1'b0;
         EDGE_RISE: edge_hit = WAKEUP_IN && !wake_q_reg;
         EDGE_FALL: edge_hit = !WAKEUP_IN && wake_q_reg;
         EDGE_BOTH: edge_hit = WAKEUP_IN != wake_q_reg;
      endcase
   end

   // pins hold until a command or an alarm shut-down; ack beats shut-down in one write
   always_comb begin
      osc_q_next    = osc_stable;
      lock_q_next   = pll_lock;
      wake_q_next   = WAKEUP_IN;
      alarm_q_next  = RTC_ALARM_IN;
      shd_pin_next  = shd_pin_reg;
      ack_pin_next  = ack_pin_reg;
      wake_req_next = wake_evt;
      if (wr_cmd && HWDATA_IN[CMD_WAKE_ACK_BIT])
         ack_pin_next = pin_drive(mode_reg[MODE_ACK_SEL_LSB +: 2], ack_pin_reg);
      else if ((wr_cmd && HWDATA_IN[CMD_SHUTDOWN_BIT]) || alarm_shd)
         shd_pin_next = pin_drive(mode_reg[MODE_SHD_SEL_LSB +: 2], shd_pin_reg);
   end

   // pin and edge registers
   always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN) begin
         osc_q_reg    <= 1'b0;
         lock_q_reg   <= 1'b0;
         wake_q_reg   <= 1'b0;
         alarm_q_reg  <= 1'b0;
         shd_pin_reg  <= 2'b00;
         ack_pin_reg  <= 2'b00;
         wake_req_reg <= 1'b0;
      end else begin
         osc_q_reg    <= osc_q_next;
         lock_q_reg   <= lock_q_next;
         wake_q_reg   <= wake_q_next;
         alarm_q_reg  <= alarm_q_next;
         shd_pin_reg  <= shd_pin_next;
         ack_pin_reg  <= ack_pin_next;
         wake_req_reg <= wake_req_next;
      end
   end

   // -----------------------------------------------------------------
   // events and interrupt
   // -----------------------------------------------------------------
   // a new event in the clearing cycle survives the write-one clear
   always_comb begin
      logic [EVT_W-1:0] set_v;
      set_v = '0;
      set_v[EVT_OSC]       = osc_stable && !osc_q_reg;
      set_v[EVT_PLL]       = pll_lock && !lock_q_reg;
      set_v[EVT_WAKE]      = wake_evt;
      set_v[EVT_ALARM_SHD] = alarm_shd;
      status_next = status_reg;
      if (wr_stat)
         status_next = status_reg & ~HWDATA_IN[EVT_W-1:0];
      status_next = status_next | set_v;
      mask_next   = mask_reg;
      if (wr_mask)
         mask_next = HWDATA_IN[EVT_W-1:0];
      if (wr_ier)
         mask_next[1:0] = mask_reg[1:0] | HWDATA_IN[1:0];
      irq_next = |(status_next & mask_next);
   end

   // event registers
   always_ff @(posedge CLK_SYS_IN) begin
      if (SRST_IN) begin
         status_reg <= '0;
         mask_reg   <= '0;
         irq_reg    <= 1'b0;
      end else begin
         status_reg <= status_next;
         mask_reg   <= mask_next;
         irq_reg    <= irq_next;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign HREADYOUT_OUT             = hready_reg;
   assign HRESP_OUT                 = hresp_reg;
   assign HRDATA_OUT                = rdata_reg;
   assign SHUTDOWN_ALARM_PIN_OE_OUT = shd_pin_reg[1];
   assign SHUTDOWN_ALARM_PIN_OUT    = shd_pin_reg[0];
   assign WAKE_ACK_PIN_OE_OUT       = ack_pin_reg[1];
   assign WAKE_ACK_PIN_OUT          = ack_pin_reg[0];
   assign WAKE_REQ_OUT              = wake_req_reg;
   assign IRQ_OUT                   = irq_reg;

endmodule // pmc_shutdown_wakeup

// File: pmc_shutdown_wakeup_assertions.sv
// checker of bus, pin and wake-up relations of the power control block
module pmc_sw_checker
   import pmc_pkg::*;
(
   input wire logic        CLK_SYS_IN,
   input wire logic        SRST_IN,
   input wire logic        HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0]  HTRANS_IN,
   input wire logic        HWRITE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic        HREADY_IN,
   input wire logic        HREADYOUT_OUT,
   input wire logic        HRESP_OUT,
   input wire logic [31:0] HRDATA_OUT,
   input wire logic        WAKEUP_IN,
   input wire logic        RTC_ALARM_IN,
   input wire logic        SHUTDOWN_ALARM_PIN_OUT,
   input wire logic        SHUTDOWN_ALARM_PIN_OE_OUT,
   input wire logic        WAKE_ACK_PIN_OUT,
   input wire logic        WAKE_ACK_PIN_OE_OUT,
   input wire logic        WAKE_REQ_OUT,
   input wire logic        IRQ_OUT
);
   logic       ap_v_reg, ap_v_next, ap_w_reg, ap_w_next, wk_reg, al_reg;
   logic [5:0] ap_a_reg, ap_a_next;
   logic [7:0] mode_reg, mode_next;
   logic       cmd_dp, rd_dp, alarm_rise, wake_cause;
   logic [1:0] shd_want, ack_want, shd_pin, ack_pin;
   // ----
   // shadow of the address phase and of the mode register
   // ----
   always_comb begin
      ap_v_next = HSEL_IN && HTRANS_IN == HTRANS_NONSEQ && HREADY_IN && !SRST_IN;
      ap_w_next = HWRITE_IN;
      ap_a_next = HADDR_IN[7:2];
      mode_next = mode_reg;
      if (SRST_IN) begin
         mode_next = MODE_RESET;
      end else if (ap_v_reg && ap_w_reg && ap_a_reg == OFS_POWER_MODE_CONFIG[7:2]) begin
         mode_next = HWDATA_IN[7:0];
      end
   end
   // inputs sampled without reset, unlike the edge detector flops, which reset low
   always_ff @(posedge CLK_SYS_IN) begin
      ap_v_reg <= ap_v_next;
      ap_w_reg <= ap_w_next;
      ap_a_reg <= ap_a_next;
      mode_reg <= mode_next;
      wk_reg   <= WAKEUP_IN;
      al_reg   <= RTC_ALARM_IN;
   end
   assign cmd_dp     = ap_v_reg && ap_w_reg && ap_a_reg == OFS_POWER_COMMAND[7:2];
   assign rd_dp      = ap_v_reg && !ap_w_reg;
   assign alarm_rise = RTC_ALARM_IN && !al_reg;
   assign wake_cause = (WAKEUP_IN && !wk_reg && mode_reg[6]) ||
                       (!WAKEUP_IN && wk_reg && mode_reg[7]) || (alarm_rise && mode_reg[4]);
   // pin state as {enable, level}
   assign shd_want = {mode_reg[1:0] != 2'h0, mode_reg[1:0] == 2'h2};
   assign ack_want = {mode_reg[3:2] != 2'h0, mode_reg[3:2] == 2'h2};
   assign shd_pin  = {SHUTDOWN_ALARM_PIN_OE_OUT, SHUTDOWN_ALARM_PIN_OUT};
   assign ack_pin  = {WAKE_ACK_PIN_OE_OUT, WAKE_ACK_PIN_OUT};
   // ----
   // properties
   // ----
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (SRST_IN);
   a_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT) else $error("bus not ready or okay");
   a_rdata_idle: assert property (!rd_dp |-> HRDATA_OUT == 32'h0)
      else $error("read data outside a read");
   a_mode_readback: assert property (rd_dp && ap_a_reg == OFS_POWER_MODE_CONFIG[7:2]
      |-> HRDATA_OUT == {24'h0, mode_reg}) else $error("mode register read wrong");
   a_shd_cmd: assert property (
      cmd_dp && HWDATA_IN[1:0] == 2'h1 && mode_reg[1:0] != 2'h3
      |=> shd_pin == $past(shd_want)) else $error("shut-down pin not set by command");
   a_ack_cmd: assert property (
      cmd_dp && HWDATA_IN[1] && mode_reg[3:2] != 2'h3
      |=> ack_pin == $past(ack_want)) else $error("ack pin not set by command");
   a_ack_priority: assert property (
      cmd_dp && HWDATA_IN[1:0] == 2'h3 |=> $stable(shd_pin))
      else $error("shut-down pin moved on joint command");
   a_shd_hold: assert property (
      !(cmd_dp && HWDATA_IN[0]) && !alarm_rise |=> $stable(shd_pin))
      else $error("shut-down pin moved without cause");
   a_ack_hold: assert property (!(cmd_dp && HWDATA_IN[1]) |=> $stable(ack_pin))
      else $error("ack pin moved without cause");
   a_alarm_shd: assert property (
      alarm_rise && mode_reg[5:4] == 2'h2 && mode_reg[1:0] != 2'h3 && !(cmd_dp && HWDATA_IN[1])
      |=> shd_pin == $past(shd_want)) else $error("alarm shut-down not applied");
   a_wake_exact: assert property (1'b1 |=> WAKE_REQ_OUT == $past(wake_cause))
      else $error("wake request does not follow its cause");
   c_joint_cmd: cover property (cmd_dp && HWDATA_IN[1:0] == 2'h3);
   c_wake: cover property (WAKE_REQ_OUT);
   c_irq: cover property (IRQ_OUT);
endmodule // pmc_sw_checker

// File: pmc_supply_model.sv
// model of the wake-up source, alarm line and slow clock facing the power control block
module pmc_supply_model (
   input  wire logic clk_in,
   input  wire logic rst_in,
   output logic      wake_out = 1'b0,
   output logic      alarm_out = 1'b0,
   output logic      tick_out = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // slow clock shortened to one tick every two cycles to keep counts brief
   always @(posedge clk_in) begin
      tick_out <= rst_in ? 1'b0 : ~tick_out;
   end
   // wake level held three cycles so each edge is seen alone
   task automatic set_wake(input logic v);
      @(posedge clk_in);
      wake_out <= v;
      repeat (3) @(posedge clk_in);
   endtask
   task automatic alarm_pulse();
      @(posedge clk_in);
      alarm_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      alarm_out <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask
endmodule // pmc_supply_model

// File: test_shutdown_wakeup_power_control.sv
// self-checking bench of the shut-down and wake-up power control block
module test_shutdown_wakeup_power_control
   import pmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   wire         hready, hresp, shd, shd_oe, ack, ack_oe, wake_req, irq, wake, alarm, tick;
   wire  [31:0] hrdata;
   int          bad_count = 0, checked = 0, cyc = 0, req_cnt = 0;
   always #2.5 clk = ~clk;
   pmc_shutdown_wakeup DUT (
      .CLK_SYS_IN(clk), .SRST_IN(srst), .HSEL_IN(hsel), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
      .HREADY_IN(hready), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .HRDATA_OUT(hrdata),
      .SLOW_TICK_IN(tick), .WAKEUP_IN(wake), .RTC_ALARM_IN(alarm),
      .SHUTDOWN_ALARM_PIN_OUT(shd), .SHUTDOWN_ALARM_PIN_OE_OUT(shd_oe),
      .WAKE_ACK_PIN_OUT(ack), .WAKE_ACK_PIN_OE_OUT(ack_oe),
      .WAKE_REQ_OUT(wake_req), .IRQ_OUT(irq));
   pmc_supply_model sup (.clk_in(clk), .rst_in(srst), .wake_out(wake), .alarm_out(alarm),
      .tick_out(tick));
   // ----
   // shared tasks
   // ----
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // a hang in any wait ends here, counted as a mismatch
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         final_report();
      end
   end
   always @(posedge clk) begin
      if (wake_req === 1'b1) req_cnt++;
   end
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // one single transfer; address phase held until ready, data taken at the second edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(n, r, e);
   endtask
   function automatic logic [1:0] pin(input int b);
      return b ? {ack_oe, ack} : {shd_oe, shd};
   endfunction
   // ----
   // scenarios
   // ----
   task automatic t_regs();
      rdc("mode reset", OFS_POWER_MODE_CONFIG, 32'h1);
      rdc("command reads zero", OFS_POWER_COMMAND, 32'h0);
      rdc("unmapped", 8'h3C, 32'h0);
      wr(OFS_OSC_PLL_STATUS, 32'hFFFFFFFF);
      rdc("status read-only", OFS_OSC_PLL_STATUS, 32'h0);
      chk("okay", hresp, 32'h0);
      chk("pins after reset", {pin(0), pin(1)}, 32'h0);
      $display("test registers done");
   endtask
   task automatic t_pins(input int b);
      for (int s = 0; s < 3; s++) begin
         wr(OFS_POWER_MODE_CONFIG, 32'(s << (2 * b)));
         wr(OFS_POWER_COMMAND, 32'(1 << b));
         @(posedge clk);
         chk("pin select", pin(b), {s != 0, s == 2});
      end
      // reserved code, then a zero command: neither may move the pin
      wr(OFS_POWER_MODE_CONFIG, 32'(3 << (2 * b)));
      wr(OFS_POWER_COMMAND, 32'(1 << b));
      wr(OFS_POWER_COMMAND, 32'h0);
      @(posedge clk);
      chk("pin kept", pin(b), 2'h3);
      $display("test pins %0d done", b);
   endtask
   task automatic t_both();
      wr(OFS_POWER_MODE_CONFIG, 32'h04);
      wr(OFS_POWER_COMMAND, 32'h3);
      @(posedge clk);
      chk("ack wins", pin(1), 2'h2);
      chk("shut-down kept", pin(0), 2'h3);
      $display("test joint command done");
   endtask
   task automatic t_wake();
      int n;
      for (int e = 0; e < 4; e++) begin
         wr(OFS_POWER_MODE_CONFIG, 32'(e << MODE_EDGE_LSB));
         n = req_cnt;
         sup.set_wake(1'b1);
         sup.set_wake(1'b0);
         chk("wake edges", req_cnt - n, e % 2 + e / 2);
      end
      $display("test wake edges done");
   endtask
   task automatic alarm_case(input logic [7:0] m, input int dq, input logic [1:0] ps);
      int n;
      wr(OFS_POWER_MODE_CONFIG, {24'h0, m});
      n = req_cnt;
      sup.alarm_pulse();
      chk("alarm wake", req_cnt - n, dq);
      chk("alarm shut-down", pin(0), ps);
      $display("test alarm %h done", m);
   endtask
   task automatic t_osc_irq();
      rdc("status off", OFS_OSC_PLL_STATUS, 32'h0);
      wr(OFS_OSC_PLL_CONFIG, 32'h02020302);
      rdc("status starting", OFS_OSC_PLL_STATUS, 32'h0);
      repeat (8) @(posedge clk);
      rdc("status counting", OFS_OSC_PLL_STATUS, 32'h0);
      repeat (60) @(posedge clk);
      rdc("status locked", OFS_OSC_PLL_STATUS, 32'h3);
      wr(OFS_OSC_PLL_CONFIG, 32'h3F020402);
      rdc("pll relocking", OFS_OSC_PLL_STATUS, 32'h1);
      repeat (140) @(posedge clk);
      rdc("pll relocked", OFS_OSC_PLL_STATUS, 32'h3);
      chk("irq masked", irq, 32'h0);
      wr(OFS_INT_ENABLE_SET, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq enabled", irq, 32'h1);
      wr(OFS_INT_ENABLE_SET, 32'h0);
      rdc("mask kept", OFS_EVENT_MASK, 32'h1);
      rdc("events latched", OFS_EVENT_STATUS, 32'hF);
      wr(OFS_EVENT_STATUS, 32'hF);
      repeat (2) @(posedge clk);
      chk("irq cleared", irq, 32'h0);
      wr(OFS_OSC_PLL_CONFIG, 32'h0);
      rdc("status disabled", OFS_OSC_PLL_STATUS, 32'h0);
      wr(OFS_EVENT_MASK, 32'h2);
      rdc("mask replaced", OFS_EVENT_MASK, 32'h2);
      $display("test oscillator and irq done");
   endtask
   task automatic t_reset();
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      chk("pins after reset", {pin(0), pin(1)}, 32'h0);
      rdc("mode after reset", OFS_POWER_MODE_CONFIG, 32'h1);
      $display("test second reset done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      t_regs();
      t_pins(0);
      t_pins(1);
      t_both();
      t_wake();
      alarm_case(8'h10, 1, 2'h3);
      alarm_case(8'h30, 1, 2'h3);
      alarm_case(8'h20, 0, 2'h0);
      t_osc_irq();
      t_reset();
      final_report();
   end
endmodule // test_shutdown_wakeup_power_control
bind pmc_shutdown_wakeup pmc_sw_checker u_chk (
   .CLK_SYS_IN(CLK_SYS_IN), .SRST_IN(SRST_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN),
   .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HWDATA_IN(HWDATA_IN),
   .HREADY_IN(HREADY_IN), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
   .HRDATA_OUT(HRDATA_OUT), .WAKEUP_IN(WAKEUP_IN), .RTC_ALARM_IN(RTC_ALARM_IN),
   .SHUTDOWN_ALARM_PIN_OUT(SHUTDOWN_ALARM_PIN_OUT),
   .SHUTDOWN_ALARM_PIN_OE_OUT(SHUTDOWN_ALARM_PIN_OE_OUT),
   .WAKE_ACK_PIN_OUT(WAKE_ACK_PIN_OUT), .WAKE_ACK_PIN_OE_OUT(WAKE_ACK_PIN_OE_OUT),
   .WAKE_REQ_OUT(WAKE_REQ_OUT), .IRQ_OUT(IRQ_OUT));
